// ==== common/porhs_pkg.sv ====
package porhs_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned CLK_PER_MS      = CLK_HZ / 1000;
  // delay windows in ms; the timer aims at the least value of each
  localparam int unsigned DLY_LONG_MIN_MS  = 100;
  localparam int unsigned DLY_LONG_MAX_MS  = 300;
  localparam int unsigned DLY_SHORT_MIN_MS = 4;
  localparam int unsigned DLY_SHORT_MAX_MS = 12;
  // longest supply ramp in ms
  localparam int unsigned RAMP_LONG_MS    = 100;
  localparam int unsigned RAMP_SHORT_MS   = 4;
  localparam int unsigned DLY_LONG_CYC    = DLY_LONG_MIN_MS * CLK_PER_MS;
  localparam int unsigned DLY_SHORT_CYC   = DLY_SHORT_MIN_MS * CLK_PER_MS;
  localparam int unsigned RAMP_LONG_CYC   = RAMP_LONG_MS * CLK_PER_MS;
  localparam int unsigned RAMP_SHORT_CYC  = RAMP_SHORT_MS * CLK_PER_MS;
  localparam int unsigned CNT_W           = 32;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic core;
    logic auxiliary;
    logic io_bank;
    logic programming;
    logic predriver;
    logic power_technology;
    logic cfg_memory;
  } porhs_supply_type;

  typedef struct packed {
    logic complete;
    logic chain_enable_out;
    logic status;
  } porhs_cfgpin_type;

  typedef enum logic [1:0] {
    ST_RAMP    = 2'b00,
    ST_DELAY   = 2'b01,
    ST_RUN     = 2'b11,
    ST_STALLED = 2'b10
  } porhs_state_type;
endpackage : porhs_pkg

// ==== rtl/porhs_sync.sv ====
module porhs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  // ****************************************
  // two-stage synchroniser per bit
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          meta_r[g] <= 1'b0;
          o_q[g]    <= 1'b0;
        end else begin
          meta_r[g] <= i_d[g];
          o_q[g]    <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule // porhs_sync

// ==== rtl/porhs_top.sv ====
// Function
// - main reset stays asserted until satellite and regulator monitors both report good
// - configuration may start only after the main reset has released
// - delay-select low gives a 100-300 ms delay, high gives 4-12 ms
// - supplies late beyond the ramp limit leave I/O and programming tri-stated
// - hot-insert guard turns outputs off while any guarded supply is low
// - config complete, chain enable out and status pins bypass the guard
// - general I/O stays tri-stated until user mode after configuration
// - satellite ready is the AND of predriver, programming, auxiliary, core, technology
// - regulator check of configuration memory supply gates the final reset trip
module porhs_top
  import porhs_pkg::*;
#(
  parameter int unsigned DLY_LONG   = DLY_LONG_CYC,
  parameter int unsigned DLY_SHORT  = DLY_SHORT_CYC,
  parameter int unsigned RAMP_LONG  = RAMP_LONG_CYC,
  parameter int unsigned RAMP_SHORT = RAMP_SHORT_CYC
) (
  input  wire logic             I_CLK_SYS,
  input  wire logic             I_RST_B,
  input  porhs_pkg::porhs_supply_type I_SUPPLY_GOOD,
  input  wire logic             I_RESET_DELAY_SELECT,
  input  wire logic             I_CONFIG_DONE,
  input  porhs_pkg::porhs_cfgpin_type I_CFG_PIN_OUT,
  input  porhs_pkg::porhs_cfgpin_type I_CFG_PIN_OE,
  input  wire logic             I_USER_IO_OE,
  output logic                  O_MAIN_RESET,
  output logic                  O_CONFIG_ALLOW,
  output logic                  O_HOT_INSERT_GUARD,
  output logic                  O_USER_MODE,
  output logic                  O_USER_IO_OE,
  output logic                  O_PROG_REG_TRISTATE,
  output porhs_pkg::porhs_cfgpin_type O_CFG_PIN_OUT,
  output porhs_pkg::porhs_cfgpin_type O_CFG_PIN_OE
);
  import porhs_pkg::*;

  typedef struct packed {
    porhs_state_type  state;
    logic [CNT_W-1:0] dly_cnt;
    logic [CNT_W-1:0] ramp_cnt;
    logic             delay_sel;
    logic             main_reset;
    logic             config_allow;
    logic             guard;
    logic             user_mode;
    logic             user_io_oe;
    logic             prog_tristate;
    porhs_cfgpin_type cfg_out;
    porhs_cfgpin_type cfg_oe;
  } porhs_regs_type;

  localparam porhs_regs_type REGS_RST = '{
    state:         ST_RAMP,
    dly_cnt:       '0,
    ramp_cnt:      '0,
    delay_sel:     1'b0,
    main_reset:    1'b1,
    config_allow:  1'b0,
    guard:         1'b1,
    user_mode:     1'b0,
    user_io_oe:    1'b0,
    prog_tristate: 1'b1,
    cfg_out:       '0,
    cfg_oe:        '0
  };

  localparam int SUP_W = $bits(porhs_supply_type);

  // ****************************************
  // pin synchronisers
  // ****************************************
  // monitor levels and pins are asynchronous to the timer clock
  logic [SUP_W+1:0]  sync_q;
  porhs_supply_type  sup;
  logic              sel_s;
  logic              done_s;

  porhs_sync #(
    .W (SUP_W + 2)
  ) u_sync (
    .i_clk   (I_CLK_SYS),
    .i_rst_b (I_RST_B),
    .i_d     ({I_SUPPLY_GOOD, I_RESET_DELAY_SELECT, I_CONFIG_DONE}),
    .o_q     (sync_q)
  );

  assign sup    = porhs_supply_type'(sync_q[SUP_W+1:2]);
  assign sel_s  = sync_q[1];
  assign done_s = sync_q[0];

  // ****************************************
  // monitor conditions
  // ****************************************
  logic satellite_ok;
  logic regulator_ok;
  logic both_ok;
  logic guard_cond;

  assign satellite_ok = sup.predriver & sup.programming & sup.auxiliary
                      & sup.core & sup.power_technology;
  assign regulator_ok = sup.cfg_memory;
  assign both_ok      = satellite_ok & regulator_ok;
  assign guard_cond   = ~(sup.core & sup.auxiliary & sup.io_bank
                      & sup.programming & sup.predriver);

  // ****************************************
  // sequencer
  // ****************************************
  porhs_regs_type r;
  porhs_regs_type r_nxt;
  logic [CNT_W-1:0] dly_len;
  logic [CNT_W-1:0] ramp_len;

  // delay select is latched at each fresh ramp so a glitch mid-delay cannot shorten it
  assign dly_len  = r.delay_sel ? CNT_W'(DLY_SHORT) : CNT_W'(DLY_LONG);
  assign ramp_len = sel_s ? CNT_W'(RAMP_SHORT) : CNT_W'(RAMP_LONG);

  always_comb begin
    r_nxt       = r;
    r_nxt.guard = guard_cond;
    case (r.state)
      ST_RAMP: begin
        r_nxt.delay_sel = sel_s;
        r_nxt.dly_cnt   = '0;
        if (both_ok) begin
          r_nxt.state = ST_DELAY;
        end else if (r.ramp_cnt >= ramp_len - CNT_W'(1)) begin
          r_nxt.state = ST_STALLED;
        end else begin
          r_nxt.ramp_cnt = r.ramp_cnt + CNT_W'(1);
        end
      end
      ST_DELAY: begin
        if (!both_ok) begin
          r_nxt.dly_cnt = '0;
          r_nxt.state   = ST_RAMP;
        end else if (r.dly_cnt >= dly_len - CNT_W'(1)) begin
          r_nxt.state      = ST_RUN;
          r_nxt.main_reset = 1'b0;
        end else begin
          r_nxt.dly_cnt = r.dly_cnt + CNT_W'(1);
        end
      end
      ST_RUN: begin
        if (!both_ok) begin
          // losing a monitor re-arms the whole sequence
          r_nxt            = REGS_RST;
          r_nxt.guard      = guard_cond;
          r_nxt.delay_sel  = sel_s;
        end else begin
          r_nxt.prog_tristate = 1'b0;
          r_nxt.config_allow  = 1'b1;
          if (done_s) begin
            r_nxt.user_mode = 1'b1;
          end
        end
      end
      ST_STALLED: begin
        // no reset event: stays tri-stated until a full reset
        r_nxt.main_reset    = 1'b1;
        r_nxt.prog_tristate = 1'b1;
      end
      default: begin
        r_nxt = REGS_RST;
      end
    endcase
    r_nxt.user_io_oe = r_nxt.user_mode & ~guard_cond & I_USER_IO_OE;
    // configuration handshake pins pass ungated
    r_nxt.cfg_out    = I_CFG_PIN_OUT;
    r_nxt.cfg_oe     = I_CFG_PIN_OE;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      r <= REGS_RST;
    end else begin
      r <= r_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign O_MAIN_RESET        = r.main_reset;
  assign O_CONFIG_ALLOW      = r.config_allow;
  assign O_HOT_INSERT_GUARD  = r.guard;
  assign O_USER_MODE         = r.user_mode;
  assign O_USER_IO_OE        = r.user_io_oe;
  assign O_PROG_REG_TRISTATE = r.prog_tristate;
  assign O_CFG_PIN_OUT       = r.cfg_out;
  assign O_CFG_PIN_OE        = r.cfg_oe;
endmodule // porhs_top

// ==== testbench/porhs_board_model.sv ====
// board supplies: core ramps first, auxiliary only once core is fully up
module porhs_board_model
  import porhs_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_power_on,
  input  porhs_pkg::porhs_supply_type i_kill,
  output porhs_pkg::porhs_supply_type o_supply
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] step_r = 3'h0;
  always @(posedge i_clk) begin
    step_r <= !i_power_on ? 3'h0 : (step_r == 3'h4) ? step_r : step_r + 3'h1;
  end
  always_comb begin
    o_supply                  = '0;
    o_supply.core             = step_r >= 3'h1;
    o_supply.auxiliary        = step_r >= 3'h3;
    o_supply.io_bank          = step_r >= 3'h2;
    o_supply.programming      = step_r >= 3'h2;
    o_supply.predriver        = step_r >= 3'h2;
    o_supply.power_technology = step_r >= 3'h2;
    o_supply.cfg_memory       = step_r >= 3'h4;
    // a killed rail reads low at once, no slow decay modelled
    o_supply                  = o_supply & ~i_kill;
  end
endmodule // porhs_board_model

// ==== testbench/porhs_top_monitor.sv ====
module porhs_top_monitor
  import porhs_pkg::*;
#(
  parameter int unsigned DLY_SHORT = DLY_SHORT_CYC
) (
  input wire logic                   I_CLK_SYS,
  input wire logic                   I_RST_B,
  input porhs_pkg::porhs_supply_type I_SUPPLY_GOOD,
  input wire logic                   I_USER_IO_OE,
  input porhs_pkg::porhs_cfgpin_type I_CFG_PIN_OUT,
  input porhs_pkg::porhs_cfgpin_type I_CFG_PIN_OE,
  input wire logic                   O_MAIN_RESET,
  input wire logic                   O_CONFIG_ALLOW,
  input wire logic                   O_HOT_INSERT_GUARD,
  input wire logic                   O_USER_MODE,
  input wire logic                   O_USER_IO_OE,
  input wire logic                   O_PROG_REG_TRISTATE,
  input porhs_pkg::porhs_cfgpin_type O_CFG_PIN_OUT,
  input porhs_pkg::porhs_cfgpin_type O_CFG_PIN_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  porhs_supply_type s;
  logic sat, both, five;
  logic [CNT_W-1:0] run_r;
  assign s = I_SUPPLY_GOOD;
  assign sat = s.predriver & s.programming & s.auxiliary & s.core & s.power_technology;
  assign both = sat & s.cfg_memory;
  assign five = s.core & s.auxiliary & s.io_bank & s.programming & s.predriver;
  // saturates so a long run never wraps back under the delay
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) run_r <= '0;
    else run_r <= !both ? '0 : (run_r == '1) ? run_r : run_r + 1'b1;
  end
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);
  sequence s_sat_lost; !sat [*4]; endsequence
  sequence s_mem_lost; !s.cfg_memory [*4]; endsequence
  sequence s_rail_low; !five [*4]; endsequence
  sequence s_rail_ok; five [*4]; endsequence
  a_sat_holds_reset: assert property (s_sat_lost |=> O_MAIN_RESET)
    else $error("main reset low with satellite supplies lost");
  a_mem_holds_reset: assert property (s_mem_lost |=> O_MAIN_RESET)
    else $error("main reset low with memory supply lost");
  a_guard_on: assert property (s_rail_low |=> O_HOT_INSERT_GUARD)
    else $error("guard off while a rail is low");
  a_guard_off: assert property (s_rail_ok |=> !O_HOT_INSERT_GUARD)
    else $error("guard stuck on with rails good");
  a_config_after_reset: assert property (
    $rose(O_CONFIG_ALLOW) |-> !O_MAIN_RESET && !$past(O_MAIN_RESET))
    else $error("configuration allowed during main reset");
  a_prog_held_tristate: assert property (
    O_MAIN_RESET && $past(O_MAIN_RESET) |-> O_PROG_REG_TRISTATE)
    else $error("programming registers driven in reset");
  a_delay_min_run: assert property ($fell(O_MAIN_RESET) |-> run_r >= DLY_SHORT)
    else $error("reset released before delay of steady supplies");
  a_pins_bypass: assert property (
    O_CFG_PIN_OUT == $past(I_CFG_PIN_OUT) && O_CFG_PIN_OE == $past(I_CFG_PIN_OE))
    else $error("configuration pins not passed through");
  // mode and guard are registered in the same cycle as the enable, so compare them unshifted
  a_io_gated: assert property (
    O_USER_IO_OE |-> O_USER_MODE && !O_HOT_INSERT_GUARD && $past(I_USER_IO_OE))
    else $error("general output enabled outside user mode");
endmodule // porhs_top_monitor

bind porhs_top porhs_top_monitor #(.DLY_SHORT(DLY_SHORT)) u_porhs_top_monitor (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B), .I_SUPPLY_GOOD(I_SUPPLY_GOOD),
  .I_USER_IO_OE(I_USER_IO_OE), .I_CFG_PIN_OUT(I_CFG_PIN_OUT), .I_CFG_PIN_OE(I_CFG_PIN_OE),
  .O_MAIN_RESET(O_MAIN_RESET), .O_CONFIG_ALLOW(O_CONFIG_ALLOW),
  .O_HOT_INSERT_GUARD(O_HOT_INSERT_GUARD), .O_USER_MODE(O_USER_MODE),
  .O_USER_IO_OE(O_USER_IO_OE), .O_PROG_REG_TRISTATE(O_PROG_REG_TRISTATE),
  .O_CFG_PIN_OUT(O_CFG_PIN_OUT), .O_CFG_PIN_OE(O_CFG_PIN_OE));

// ==== testbench/porhs_top_bench.sv ====
module porhs_top_bench;
  import porhs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DL = 20;
  localparam int DS = 8;
  logic clk, rst_b, sel, done, power_on, user_oe;
  logic main_rst, cfg_allow, guard, user_mode, io_oe, prog_tri;
  porhs_supply_type supply, kill;
  porhs_cfgpin_type pin_out, pin_oe, o_out, o_oe;
  int miscompares = 0;
  int n_compared = 0;
  porhs_board_model u_porhs_board_model (.i_clk(clk), .i_power_on(power_on), .i_kill(kill),
    .o_supply(supply));
  porhs_top #(.DLY_LONG(DL), .DLY_SHORT(DS), .RAMP_LONG(40), .RAMP_SHORT(16)) u_porhs_top (
    .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_SUPPLY_GOOD(supply), .I_RESET_DELAY_SELECT(sel),
    .I_CONFIG_DONE(done), .I_CFG_PIN_OUT(pin_out), .I_CFG_PIN_OE(pin_oe),
    .I_USER_IO_OE(user_oe), .O_MAIN_RESET(main_rst), .O_CONFIG_ALLOW(cfg_allow),
    .O_HOT_INSERT_GUARD(guard), .O_USER_MODE(user_mode), .O_USER_IO_OE(io_oe),
    .O_PROG_REG_TRISTATE(prog_tri), .O_CFG_PIN_OUT(o_out), .O_CFG_PIN_OE(o_oe));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic results();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // inputs always move 2 ns after the edge, clear of sampling
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic do_reset(logic s);
    {rst_b, power_on, done, user_oe, sel} = {4'h0, s};
    {kill, pin_out, pin_oe} = '0;
    step(2);
    rst_b = 1'b1;
  endtask
  task automatic wait_low(output int n);
    for (n = 0; main_rst !== 1'b0; n++) begin
      step(1);
      if (n > 300) begin
        check("reset release", 8'h00, main_rst);
        results();
      end
    end
  endtask
  task automatic power_up(int dly);
    int n;
    power_on = 1'b1;
    repeat (5) begin
      check("main_rst ramp", 8'h01, main_rst);
      step(1);
    end
    wait_low(n);
    check("delay window", 8'h01, n >= dly && n <= dly + 6);
    step(1);
    check("cfg_allow", 8'h01, cfg_allow);
    check("prog_tri", 8'h00, prog_tri);
    check("guard", 8'h00, guard);
  endtask
  task automatic guard_and_pins();
    kill.io_bank = 1'b1;
    {pin_out, pin_oe} = 6'h2F;
    step(5);
    check("guard io low", 8'h01, guard);
    check("main_rst io low", 8'h00, main_rst);
    check("pins", 8'h2F, {o_out, o_oe});
    {kill, pin_out, pin_oe} = '0;
    step(5);
    check("guard back", 8'h00, guard);
  endtask
  task automatic user_mode_io();
    // enable asked for before configuration is done must not reach the pins
    user_oe = 1'b1;
    step(4);
    check("io_oe before user", 8'h00, io_oe);
    done = 1'b1;
    step(6);
    check("user_mode", 8'h01, user_mode);
    check("io_oe", 8'h01, io_oe);
    kill.predriver = 1'b1;
    step(5);
    check("io_oe guarded", 8'h00, io_oe);
    check("main_rst predriver", 8'h01, main_rst);
  endtask
  task automatic drop_in_delay();
    int n;
    power_on = 1'b1;
    step(15);
    kill.cfg_memory = 1'b1;
    step(2);
    check("main_rst mem drop", 8'h01, main_rst);
    kill = '0;
    wait_low(n);
    check("restart from zero", 8'h01, n >= DL);
  endtask
  task automatic late_ramp();
    step(50);
    power_on = 1'b1;
    step(40);
    check("main_rst stalled", 8'h01, main_rst);
    check("prog_tri stalled", 8'h01, prog_tri);
    check("cfg_allow stalled", 8'h00, cfg_allow);
  endtask
  initial begin
    do_reset(1'b1);
    power_up(DS);
    guard_and_pins();
    user_mode_io();
    do_reset(1'b0);
    power_up(DL);
    do_reset(1'b0);
    drop_in_delay();
    do_reset(1'b1);
    late_ramp();
    results();
  end
endmodule // porhs_top_bench
